// ### hw/dsp_port.sv
// Functional notes
// R1 - Two beats per lane form one location
// R2 - Both beats unmasked: store whole lane word
// R3 - First beat only: keep stored second byte
// R4 - Second beat only: keep stored first byte
// R5 - Both beats masked: lane left unchanged
// R6 - Any half write turns correction off
// R7 - Correction stays off until power down; code turns it back on at rst
// R8 - Mask zero bits 8:0, mask one 17:9
// R9 - Wide part: masks two, three upper lanes
// R10 - Lane masks act independently of each other
// R11 - Read select low reads, high floats outputs
// R12 - Read beats appear at n+1.5 and n+2
// R13 - Write select low captures two data beats
// R14 - Write select high ignores address and data
// R15 - Controller gives write address on second edge
// R16 - Free counter periodically triggers impedance evaluation
// R17 - Each evaluation moves code one step most
// R18 - Ports independent; reads see newest data
module dsp_port #(
   parameter int LANES = dsp_pkg::LANES_X36,
   parameter int ADDR_W = dsp_pkg::ADDR_W_DEFAULT,
   parameter int CAL_CYCLES = dsp_pkg::CAL_INTERVAL_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Half-cycle marker: low on the edge that stands for the input clock rise
   output logic k_phase,
   // Shared address, read at the first edge, write at the second
   input wire logic [ADDR_W-1:0] addr,
   // Read port
   input wire logic read_n,
   output logic [LANES*dsp_pkg::BYTE_W-1:0] q,
   output logic q_oe,
   // Write port
   input wire logic write_n,
   input wire logic [LANES*dsp_pkg::BYTE_W-1:0] d,
   input wire logic [LANES-1:0] lane_write_mask_n,
   // Correction status
   output logic ecc_on,
   // Impedance comparator inputs and driver code
   input wire logic imp_cmp_up,
   input wire logic imp_cmp_down,
   output logic [dsp_pkg::IMP_CODE_W-1:0] drive_code
);
   import dsp_pkg::*;

   localparam int DW = LANES * BYTE_W;
   localparam int DEPTH = 1 << ADDR_W;
   localparam int CNT_W = (CAL_CYCLES > 2) ? $clog2(CAL_CYCLES) : 1;

   generate
      if (!(LANES == LANES_X18 || LANES == LANES_X36)) begin : g_bad_lanes
         $error("dsp_port: LANES must be 2 or 4");
      end
      if (CAL_CYCLES < 2 || ADDR_W < 1) begin : g_bad_sizes
         $error("dsp_port: CAL_CYCLES must be at least 2, ADDR_W at least 1");
      end
   endgenerate

   // Check bits over one 18-bit lane word, data at non-power-of-two positions
   function automatic logic [CHECK_W-1:0] ham_check(input logic [LANE_W-1:0] w);
      logic [CHECK_W-1:0] c;
      int k;
      c = '0;
      k = 0;
      for (int p = 1; p <= CODE_LEN; p++) begin
         if ((p & (p - 1)) != 0) begin
            if (w[k]) begin
               c = c ^ CHECK_W'(p);
            end
            k = k + 1;
         end
      end
      return c;
   endfunction

   // Flip the data bit named by the syndrome; parity-bit hits need nothing
   function automatic logic [LANE_W-1:0] ham_fix(input logic [LANE_W-1:0] w, input logic [CHECK_W-1:0] syn);
      logic [LANE_W-1:0] r;
      int k;
      r = w;
      k = 0;
      for (int p = 1; p <= CODE_LEN; p++) begin
         if ((p & (p - 1)) != 0) begin
            if (CHECK_W'(p) == syn) begin
               r[k] = ~r[k];
            end
            k = k + 1;
         end
      end
      return r;
   endfunction

   // Storage: lane word is {second beat byte, first beat byte}
   logic [LANES*LANE_W-1:0] mem [DEPTH];
   logic [LANES*CHECK_W-1:0] chk [DEPTH];

   logic wr_pend;
   logic [DW-1:0] wr_d0;
   logic [LANES-1:0] wr_m0;
   logic rd_pend;
   logic [ADDR_W-1:0] rd_addr;
   logic second_beat;
   logic [DW-1:0] beat1_hold;
   logic [CNT_W-1:0] cal_count;
   logic [1:0] imp_s1;
   logic [1:0] imp_s2;
   logic [1:0] imp_s3;
   logic [1:0] imp_req;

   // Edge roles: even edges act as the input clock rise, odd ones as its complement
   wire k_rise = !k_phase;
   wire wr_take = k_rise && !write_n; // [R13] [R14]
   wire rd_take = k_rise && !read_n; // [R11]
   wire wr_commit = k_phase && wr_pend; // [R13] [R15]

   // Per-lane, per-beat byte enables from the two sampled masks
   wire [LANES-1:0] we0 = {LANES{wr_commit}} & ~wr_m0; // [R3] [R5] [R10]
   wire [LANES-1:0] we1 = {LANES{wr_commit}} & ~lane_write_mask_n; // [R4] [R10]
   wire [LANES-1:0] we_full = we0 & we1; // [R2]
   wire [LANES-1:0] half_lane = {LANES{wr_commit}} & (wr_m0 ^ lane_write_mask_n); // [R6]

   // Phase marker runs from reset onward
   always_ff @(posedge clock) begin
      if (rst) begin
         k_phase <= 1'b0;
      end else begin
         k_phase <= ~k_phase;
      end
   end

   // First write beat and its masks, taken with the command
   always_ff @(posedge clock) begin
      if (rst) begin
         wr_pend <= 1'b0;
         wr_d0 <= '0;
         wr_m0 <= '1;
      end else begin
         wr_pend <= wr_take; // [R13] [R14]
         if (wr_take) begin
            wr_d0 <= d; // [R1]
            wr_m0 <= lane_write_mask_n;
         end
      end
   end

   // Array write on the second edge with the address given there
   always_ff @(posedge clock) begin
      for (int l = 0; l < LANES; l++) begin
         if (we0[l]) begin
            mem[addr][l*LANE_W +: BYTE_W] <= wr_d0[l*BYTE_W +: BYTE_W]; // [R1] [R8] [R9] [R15]
         end
         if (we1[l]) begin
            mem[addr][l*LANE_W+BYTE_W +: BYTE_W] <= d[l*BYTE_W +: BYTE_W]; // [R1] [R8] [R9]
         end
         if (we_full[l]) begin
            chk[addr][l*CHECK_W +: CHECK_W] <= ham_check({d[l*BYTE_W +: BYTE_W], wr_d0[l*BYTE_W +: BYTE_W]}); // [R2]
         end
      end
   end

   // Stale check bits after a partial lane write make correction unsafe, so it latches off
   always_ff @(posedge clock) begin
      if (rst) begin
         ecc_on <= 1'b1;
      end else if (|half_lane) begin
         ecc_on <= 1'b0; // [R6] [R7]
      end
   end

   // Read request waits one edge so a write committed meanwhile is seen
   dsp_rd_word_t fifo_in;
   dsp_rd_word_t fifo_out;
   logic fifo_in_ready;
   logic fifo_out_valid;
   wire rd_push = k_rise && rd_pend && fifo_in_ready; // [R18]
   wire pop = k_phase && fifo_out_valid; // [R12]

   always_ff @(posedge clock) begin
      if (rst) begin
         rd_pend <= 1'b0;
         rd_addr <= '0;
      end else if (rd_take) begin
         rd_pend <= 1'b1; // [R11] [R18]
         rd_addr <= addr;
      end else if (rd_push) begin
         rd_pend <= 1'b0;
      end
   end

   // Array read with per-lane correction while enabled
   wire [LANES*LANE_W-1:0] mem_rd = mem[rd_addr];
   wire [LANES*CHECK_W-1:0] chk_rd = chk[rd_addr];
   logic [DW-1:0] rd_b0;
   logic [DW-1:0] rd_b1;

   generate
      for (genvar l = 0; l < LANES; l++) begin : g_lane
         wire [LANE_W-1:0] raw = mem_rd[l*LANE_W +: LANE_W];
         wire [CHECK_W-1:0] syn = ham_check(raw) ^ chk_rd[l*CHECK_W +: CHECK_W];
         wire [LANE_W-1:0] fixed = ecc_on ? ham_fix(raw, syn) : raw; // [R7]
         assign rd_b0[l*BYTE_W +: BYTE_W] = fixed[BYTE_W-1:0]; // [R8] [R9]
         assign rd_b1[l*BYTE_W +: BYTE_W] = fixed[LANE_W-1:BYTE_W];
      end
   endgenerate

   assign fifo_in.beat0 = MAX_DQ_W'(rd_b0);
   assign fifo_in.beat1 = MAX_DQ_W'(rd_b1);

   // Buffer between array and output serializer, drained on odd edges only
   dsp_fifo #(
      .WIDTH($bits(dsp_rd_word_t)),
      .DEPTH(READ_FIFO_DEPTH)
   ) u_rd_fifo (
      .clock(clock),
      .rst(rst),
      .in_valid(k_rise && rd_pend),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in),
      .out_valid(fifo_out_valid),
      .out_ready(k_phase),
      .out_data(fifo_out)
   );

   // Output beats: first on an odd edge, second on the next; otherwise floating
   always_ff @(posedge clock) begin
      if (rst) begin
         q <= '0;
         q_oe <= 1'b0;
         second_beat <= 1'b0;
         beat1_hold <= '0;
      end else if (pop) begin
         q <= fifo_out.beat0[DW-1:0]; // [R12]
         q_oe <= 1'b1;
         second_beat <= 1'b1;
         beat1_hold <= fifo_out.beat1[DW-1:0];
      end else if (second_beat) begin
         q <= beat1_hold; // [R12]
         q_oe <= 1'b1;
         second_beat <= 1'b0;
      end else begin
         q_oe <= 1'b0; // [R11]
      end
   end

   // Comparator pins come from analog logic: three stages, change once two agree
   always_ff @(posedge clock) begin
      if (rst) begin
         imp_s1 <= '0;
         imp_s2 <= '0;
         imp_s3 <= '0;
         imp_req <= '0;
      end else begin
         imp_s1 <= {imp_cmp_down, imp_cmp_up};
         imp_s2 <= imp_s1;
         imp_s3 <= imp_s2;
         imp_req <= (imp_s2 & imp_s3) | (imp_req & (imp_s2 | imp_s3));
      end
   end

   // Evaluation tick and single-step code moves; both requests at once means hold
   wire cal_tick = cal_count == CNT_W'(CAL_CYCLES - 1); // [R16]
   wire step_up = cal_tick && imp_req == IMP_REQ_UP && drive_code != '1; // [R17]
   wire step_dn = cal_tick && imp_req == IMP_REQ_DOWN && drive_code != '0; // [R17]

   always_ff @(posedge clock) begin
      if (rst) begin
         cal_count <= '0;
         drive_code <= IMP_CODE_RESET;
      end else begin
         cal_count <= cal_tick ? '0 : cal_count + 1'b1; // [R16]
         if (step_up) begin
            drive_code <= drive_code + 1'b1; // [R17]
         end else if (step_dn) begin
            drive_code <= drive_code - 1'b1; // [R17]
         end
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   a_full_write_store: assert property ( // [R2]
      (k_phase && wr_pend && !wr_m0[0] && !lane_write_mask_n[0])
      |=> mem[$past(addr)][LANE_W-1:0] == {$past(d[BYTE_W-1:0]), $past(wr_d0[BYTE_W-1:0])})
      else $error("full write did not store both beats of lane 0");

   a_half_beat_one: assert property ( // [R3]
      (k_phase && wr_pend && !wr_m0[0] && lane_write_mask_n[0])
      |=> mem[$past(addr)][LANE_W-1:0] == {$past(mem[addr][LANE_W-1:BYTE_W]), $past(wr_d0[BYTE_W-1:0])})
      else $error("first-beat half write changed the wrong byte");

   a_half_beat_two: assert property ( // [R4]
      (k_phase && wr_pend && wr_m0[1] && !lane_write_mask_n[1])
      |=> mem[$past(addr)][LANE_W +: LANE_W] == {$past(d[BYTE_W +: BYTE_W]), $past(mem[addr][LANE_W +: BYTE_W])})
      else $error("second-beat half write changed the wrong byte");

   a_abort_keeps: assert property ( // [R5]
      (k_phase && wr_pend && wr_m0[1] && lane_write_mask_n[1])
      |=> mem[$past(addr)][2*LANE_W-1:LANE_W] == $past(mem[addr][2*LANE_W-1:LANE_W]))
      else $error("aborted lane 1 was modified");

   a_half_kills_ecc: assert property ( // [R6]
      (k_phase && wr_pend && (wr_m0 != lane_write_mask_n)) |=> !ecc_on)
      else $error("correction still on after a half write");

   a_ecc_stays_off: assert property ( // [R7]
      !ecc_on |=> !ecc_on)
      else $error("correction came back on");

   a_read_beats: assert property ( // [R12]
      (k_rise && !read_n) |-> ##4 (q_oe && $past(pop)) ##1 (q_oe && !second_beat))
      else $error("read beats not driven on the third and fourth edges");

   a_read_deselect: assert property ( // [R11]
      (k_rise && read_n && $past(read_n, 2)) |-> ##4 !q_oe ##1 !q_oe)
      else $error("outputs driven after a read deselect");

   a_write_capture: assert property ( // [R13]
      (k_rise && !write_n) |=> (wr_commit && wr_d0 == $past(d)))
      else $error("write command did not capture first beat");

   a_write_deselect: assert property ( // [R14]
      (k_rise && write_n) |=> (we0 == '0 && we1 == '0))
      else $error("deselected write touched the array");

   a_cal_restart: assert property ( // [R16]
      cal_tick |=> (cal_count == '0) ##1 (cal_count == CNT_W'(1)))
      else $error("calibration counter did not restart");

   a_cal_one_step: assert property ( // [R17]
      (drive_code == $past(drive_code)) || (drive_code == $past(drive_code) + 1'b1)
      || (drive_code == $past(drive_code) - 1'b1))
      else $error("driver code moved more than one step");
endmodule

// ### common/dsp_pkg.sv
package dsp_pkg;
   // Data lane layout
   localparam int BYTE_W = 9;
   localparam int LANE_W = 18;
   localparam int CHECK_W = 5;
   localparam int CODE_LEN = 23;
   localparam int LANES_X18 = 2;
   localparam int LANES_X36 = 4;
   localparam int MAX_DQ_W = 36;

   // Array and read path sizing
   localparam int ADDR_W_DEFAULT = 8;
   localparam int READ_FIFO_DEPTH = 4;

   // Clock and impedance calibration timing
   localparam int CLOCK_PERIOD_NS = 8;
   localparam int CAL_INTERVAL_NS = 65536;
   localparam int CAL_INTERVAL_CYCLES = CAL_INTERVAL_NS / CLOCK_PERIOD_NS;
   localparam int IMP_CODE_W = 6;
   localparam logic [IMP_CODE_W-1:0] IMP_CODE_RESET = 6'h20;

   // Comparator request codes after filtering
   localparam logic [1:0] IMP_REQ_UP = 2'h1;
   localparam logic [1:0] IMP_REQ_DOWN = 2'h2;

   // One read access: both output beats of every lane
   typedef struct packed {
      logic [MAX_DQ_W-1:0] beat1;
      logic [MAX_DQ_W-1:0] beat0;
   } dsp_rd_word_t;
endpackage

// ### hw/dsp_fifo.sv
module dsp_fifo #(
   parameter int WIDTH = 72,
   parameter int DEPTH = dsp_pkg::READ_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   import dsp_pkg::*;

   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
         $error("dsp_fifo: DEPTH must be a power of two, at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] store [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [PTR_W:0] count;

   // Handshake terms
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = count != (PTR_W + 1)'(DEPTH);
   assign out_valid = count != '0;
   assign out_data = store[rd_ptr];

   // Pointers and fill level; simultaneous push and pop keep the count
   always_ff @(posedge clock) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         count <= count + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop);
      end
   end

   // Storage, no reset needed for data words
   always_ff @(posedge clock) begin
      if (push) begin
         store[wr_ptr] <= in_data;
      end
   end
endmodule

// ### testbench/dsp_ctrl_model.sv
// Controller side of the command bus; one call issues one K-edge command
module dsp_ctrl_model (
   // Clock and phase marker
   input wire logic clock,
   input wire logic k_phase,
   // Command and data bus
   output logic [7:0] addr,
   output logic read_n,
   output logic write_n,
   output logic [dsp_pkg::MAX_DQ_W-1:0] d,
   output logic [dsp_pkg::LANES_X36-1:0] lane_write_mask_n
);
   timeunit 1ns;
   timeprecision 100ps;
   import dsp_pkg::*;

   // Idle bus at time zero
   initial begin
      addr = 8'h00;
      read_n = 1'b1;
      write_n = 1'b1;
      d = 36'h0;
      lane_write_mask_n = 4'hF;
   end

   // Launch on the edge before a K edge so back-to-back calls fill every K slot
   task automatic cmd(input logic rd, input logic [7:0] ra, input logic wr, input logic [7:0] wa,
                      input logic [35:0] d0, input logic [35:0] d1, input logic [3:0] m0, input logic [3:0] m1);
      do @(negedge clock); while (k_phase !== 1'b1);
      @(posedge clock);
      read_n <= rd;
      write_n <= wr;
      addr <= ra;
      d <= d0;
      lane_write_mask_n <= m0;
      @(posedge clock);
      read_n <= 1'b1;
      write_n <= 1'b1;
      addr <= wa;
      d <= d1;
      lane_write_mask_n <= m1;
   endtask

   // Released lines flip so stale values cannot pass for data
   task automatic idle();
      @(posedge clock);
      addr <= ~addr;
      d <= ~d;
      lane_write_mask_n <= ~lane_write_mask_n;
   endtask
endmodule

// ### testbench/dsp_port_tb.sv
module dsp_port_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import dsp_pkg::*;
   localparam int CAL = 16;
   logic clock, rst, k_phase, read_n, q_oe, write_n, ecc_on, imp_cmp_up, imp_cmp_down;
   logic [7:0] addr;
   logic [35:0] q, d;
   logic [3:0] lane_write_mask_n;
   logic [5:0] drive_code, last_code;
   logic [35:0] mem0 [256];
   logic [35:0] mem1 [256];
   logic [35:0] exp_q [$];
   int miscompares = 0;
   int check_count = 0;
   int since = 0;

   dsp_port #(.LANES(4), .ADDR_W(8), .CAL_CYCLES(CAL)) i_dsp_port (.clock(clock), .rst(rst),
      .k_phase(k_phase), .addr(addr), .read_n(read_n), .q(q), .q_oe(q_oe), .write_n(write_n), .d(d),
      .lane_write_mask_n(lane_write_mask_n), .ecc_on(ecc_on), .imp_cmp_up(imp_cmp_up),
      .imp_cmp_down(imp_cmp_down), .drive_code(drive_code));
   dsp_ctrl_model i_dsp_ctrl_model (.clock(clock), .k_phase(k_phase), .addr(addr), .read_n(read_n),
      .write_n(write_n), .d(d), .lane_write_mask_n(lane_write_mask_n));

   initial clock = 1'b0;
   always #4 clock = ~clock;

   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Update the reference array, note expected beats, then issue the command
   task automatic op(input logic rd, input logic [7:0] ra, input logic wr, input logic [7:0] wa,
                     input logic [3:0] m0, input logic [3:0] m1);
      logic [35:0] d0, d1;
      d0 = {4'($urandom()), 32'($urandom())};
      d1 = {4'($urandom()), 32'($urandom())};
      for (int l = 0; l < 4; l++) begin
         if (!wr && !m0[l]) mem0[wa][l*9+:9] = d0[l*9+:9];
         if (!wr && !m1[l]) mem1[wa][l*9+:9] = d1[l*9+:9];
      end
      if (!rd) begin
         exp_q.push_back(mem0[ra]);
         exp_q.push_back(mem1[ra]);
      end
      i_dsp_ctrl_model.cmd(rd, ra, wr, wa, d0, d1, m0, m1);
   endtask

   // Let reads drain; every noted beat must have come out
   task automatic settle(input string name);
      i_dsp_ctrl_model.idle();
      repeat (10) @(negedge clock);
      check(36'(exp_q.size()), 36'h0);
      $display("test %s done", name);
   endtask

   task automatic reset_dut();
      @(posedge clock);
      rst <= 1'b1;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      @(negedge clock);
   endtask

   // Read beats: any q_oe without a noted beat is a fault
   always @(posedge clock) begin
      if (q_oe === 1'b1) begin
         if (exp_q.size() == 0) check(36'h1, 36'h0);
         else check(q, exp_q.pop_front());
      end
   end

   // Code moves one step at a time, at most once per interval
   always @(posedge clock) begin
      since++;
      if (rst) begin
         last_code = drive_code;
         since = CAL;
      end else if (drive_code !== last_code) begin
         check(36'(since >= CAL), 36'h1);
         check(36'(drive_code == last_code + 6'h1 || drive_code == last_code - 6'h1), 36'h1);
         last_code = drive_code;
         since = 0;
      end
   end

   initial begin
      repeat (20000) @(posedge clock);
      miscompares++;
      results();
   end

   task automatic results();
      $display("comparisons %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      void'($urandom(1524));
      rst = 1'b1;
      imp_cmp_up = 1'b0;
      imp_cmp_down = 1'b0;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      @(negedge clock);
      check({35'h0, q_oe}, 36'h0);
      check({35'h0, ecc_on}, 36'h1);
      check({30'h0, drive_code}, 36'h20);
      // Full writes, then back-to-back reads with no deselect between
      for (int a = 0; a < 8; a++) op(1'b1, 8'h00, 1'b0, 8'(a), 4'h0, 4'h0);
      for (int a = 0; a < 8; a++) op(1'b0, 8'(a), 1'b1, 8'h00, 4'h0, 4'h0);
      settle("fill");
      // Deselected write with live data must leave the array alone
      op(1'b1, 8'h00, 1'b1, 8'h03, 4'h0, 4'h0);
      op(1'b0, 8'h03, 1'b1, 8'h00, 4'h0, 4'h0);
      settle("deselect");
      // Every lane mask combination, read of the same place in the same slot
      for (int c = 0; c < 16; c++) op(1'b0, 8'(c % 8), 1'b0, 8'(c % 8), 4'(c), 4'(c));
      settle("masks");
      check({35'h0, ecc_on}, 36'h1);
      // Half writes in every lane, sticky correction off
      for (int i = 0; i < 6; i++) begin
         logic [3:0] m;
         // First pass pins lane 0 to first-beat only and lane 1 to second-beat only
         m = (i == 0) ? 4'h2 : 4'($urandom());
         op(1'b0, 8'(i), 1'b0, 8'(i), m, ~m);
      end
      settle("half");
      check({35'h0, ecc_on}, 36'h0);
      op(1'b1, 8'h00, 1'b0, 8'h01, 4'h0, 4'h0);
      settle("sticky");
      check({35'h0, ecc_on}, 36'h0);
      reset_dut();
      check({35'h0, ecc_on}, 36'h1);
      // Both requests hold mid-range code, then up to the top, then down to zero
      @(posedge clock);
      imp_cmp_up <= 1'b1;
      imp_cmp_down <= 1'b1;
      repeat (6 * CAL) @(negedge clock);
      check({30'h0, drive_code}, 36'h20);
      @(posedge clock);
      imp_cmp_down <= 1'b0;
      repeat (40 * CAL) @(negedge clock);
      check({30'h0, drive_code}, 36'h3F);
      @(posedge clock);
      imp_cmp_up <= 1'b0;
      imp_cmp_down <= 1'b1;
      repeat (70 * CAL) @(negedge clock);
      check({30'h0, drive_code}, 36'h0);
      $display("test impedance done");
      results();
   end
endmodule
